// [hdl/pwr_state_mgr_defs.svh]
// Register offsets, field positions, encodings and timing figures of the power state manager.
`ifndef PWR_STATE_MGR_DEFS_SVH
`define PWR_STATE_MGR_DEFS_SVH

// Register byte offsets on the register bus.
`define PMC_OFFSET 12'h000
`define WAKE_TEST_OFFSET 12'h004
`define IRQ_FLAGS_OFFSET 12'h008
`define IRQ_ENABLE_OFFSET 12'h00c
`define PHY_CTRL_OFFSET 12'h010
`define CLK_STATUS_OFFSET 12'h014

// Field positions in power_mgmt_control.
`define PMC_READY_BIT 0
`define PMC_PULSE_SEL_BIT 1
`define PMC_ENERGY_EN_BIT 2
`define PMC_FRAME_EN_BIT 3
`define PMC_PIN_EN_BIT 4
`define PMC_WSS_LSB 8
`define PMC_PSS_LSB 12

// Field positions in the flag, enable and PHY control registers.
`define IRQ_WAKE_BIT 0
`define PHY_GEN_PD_BIT 0
`define PHY_ENERGY_PD_BIT 1

// Encodings of power_state_select and wake_source_status.
`define PSS_NORMAL 2'h0
`define PSS_WOL 2'h1
`define PSS_ENERGY 2'h2
`define WSS_FRAME 2'h2
`define WSS_ENERGY 2'h1

// Fixed pattern returned by a read of wake_test_word; the value is arbitrary.
`define WAKE_TEST_VALUE 32'h5a5a_c3c3

// Timing: clock rate, resume time and wake pin pulse length.
`define CLK_MHZ 100
`define RESUME_US 2000
`define PULSE_MS 50
`define RESUME_CYC (`RESUME_US * `CLK_MHZ)
`define PULSE_CYC (`PULSE_MS * 1000 * `CLK_MHZ)

`endif

// [hdl/pwr_state_mgr_pkg.sv]
// Types shared by the power state manager.
`default_nettype none
package pwr_state_mgr_pkg;

    // Power state of the device; resuming is the wait before ready returns.
    typedef enum logic [1:0] {
        normal_state,
        sleep_wol_state,
        sleep_energy_state,
        resuming_state
    } pwr_state_t;

    // Clock enables toward the gated blocks.
    typedef struct packed {
        logic phy;
        logic rx_pm;
        logic internal;
        logic mac;
        logic host_if;
    } clk_gate_t;

endpackage
`default_nettype wire

// [hdl/ethernet_power_state_manager.sv]
// Power state manager with APB register access, wake detection and wake pin control.
`default_nettype none
`include "pwr_state_mgr_defs.svh"

// Function
// - Writing 01 to power_state_select enters sleep_wol_state and clears ready.
// - Writing 10 to power_state_select enters sleep_energy_state and clears ready.
// - In sleep, ready stays clear and only power_mgmt_control reads are served.
// - In sleep any write to wake_test_word returns to normal_state.
// - After reset or wake, writes do nothing until the host has read once.
// - In sleep_wol_state a wake frame sets wake_source_status to 10.
// - Frame wake drives the pin only with frame and pin enables set.
// - In sleep_energy_state carrier sets status 01; pin needs energy and pin enables.
// - Carrier already present on entry to energy sleep is reported at once.
// - The internal wake event sets the irq flag regardless of pin enable.
// - The irq flag holds while the event lasts, then write-one clears it.
// - Wake pin pulses 50 ms when pulse select is one, else holds.
// - Clearing status, the matching enable or pin enable drops the wake pin.
// - In sleep_wol_state PHY, rx power logic and internal clocks run; MAC, host stop.
// - In sleep_energy_state all clocks stop; PHY energy powerdown follows only its PHY control register bit.
// - wake_source_status stays readable; clearing it only works while ready.
// - PHY general powerdown holds the PHY down; clearing it resets the PHY.
// - Configuration and register contents survive both sleep states.
// - Ready returns within 2 ms after the wake write.
module ethernet_power_state_manager
    import pwr_state_mgr_pkg::*;
#(
    parameter int unsigned RESUME_CYCLES = `RESUME_CYC,
    parameter int unsigned PULSE_CYCLES = `PULSE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_frame_detected,
    input wire logic carrier_present,
    output logic wake_event_pin,
    output logic host_irq,
    output clk_gate_t clk_gate,
    output logic phy_powerdown,
    output logic phy_energy_powerdown,
    output logic phy_reset
);

    pwr_state_t state_ff, nxt_state;
    logic ready_ff;
    logic read_seen_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic pulse_sel_ff, energy_en_ff, frame_en_ff, pin_en_ff;
    logic [1:0] wss_ff;
    logic [1:0] nxt_wss;
    logic irq_flag_ff, nxt_irq_flag;
    logic irq_en_ff;
    logic phy_gen_pd_ff, phy_energy_pd_ff;
    logic phy_reset_ff;
    logic pin_ff, pin_req_d_ff;
    logic [31:0] pulse_cnt_ff;
    logic [31:0] resume_cnt_ff;
    logic host_irq_ff;
    clk_gate_t clk_gate_ff;

    logic setup, access, rd_acc, wr_acc;
    logic sleeping, mapped, rd_ok, wr_ok, wake_wr;
    logic wr_pmc, wr_irq, wr_irq_en, wr_phy;
    logic [1:0] pss_wr;
    logic wake_event, pin_req, pin_rise;

    // Bus phases: the answer is registered in the setup cycle and given in the first access cycle.
    assign setup = psel & ~penable;
    assign access = psel & penable & pready_ff;
    assign rd_acc = access & ~pwrite;
    assign wr_acc = access & pwrite;
    assign sleeping = (state_ff == sleep_wol_state) | (state_ff == sleep_energy_state);
    assign mapped = (paddr == `PMC_OFFSET) | (paddr == `WAKE_TEST_OFFSET) | (paddr == `IRQ_FLAGS_OFFSET) |
                    (paddr == `IRQ_ENABLE_OFFSET) | (paddr == `PHY_CTRL_OFFSET) | (paddr == `CLK_STATUS_OFFSET);
    // Without ready only the control register is served to reads.
    assign rd_ok = mapped & (ready_ff | (paddr == `PMC_OFFSET));
    // Ordinary writes need ready and a prior read; others are dropped.
    assign wr_ok = mapped & ready_ff & read_seen_ff;
    // Any data written to wake_test_word while asleep wakes the device.
    assign wake_wr = wr_acc & sleeping & (paddr == `WAKE_TEST_OFFSET);
    assign wr_pmc = wr_acc & wr_ok & (paddr == `PMC_OFFSET);
    assign wr_irq = wr_acc & wr_ok & (paddr == `IRQ_FLAGS_OFFSET);
    assign wr_irq_en = wr_acc & wr_ok & (paddr == `IRQ_ENABLE_OFFSET);
    assign wr_phy = wr_acc & wr_ok & (paddr == `PHY_CTRL_OFFSET);
    assign pss_wr = pwdata[`PMC_PSS_LSB +: 2];

    // Internal wake event: a latched source whose matching enable is still set.
    assign wake_event = (wss_ff[1] & frame_en_ff) | (wss_ff[0] & energy_en_ff);
    assign pin_req = wake_event & pin_en_ff;
    assign pin_rise = pin_req & ~pin_req_d_ff;

    // Next power state.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            normal_state: begin
                if (wr_pmc && pss_wr == `PSS_WOL) begin
                    nxt_state = sleep_wol_state;
                end else if (wr_pmc && pss_wr == `PSS_ENERGY) begin
                    nxt_state = sleep_energy_state;
                end
                // Codes 00 and 11 leave the state alone.
            end
            sleep_wol_state, sleep_energy_state: begin
                if (wake_wr) begin
                    nxt_state = resuming_state;
                end
            end
            resuming_state: begin
                if (resume_cnt_ff >= RESUME_CYCLES - 32'd1) begin
                    nxt_state = normal_state;
                end
            end
        endcase
    end

    // State and ready flag; ready is set only in normal state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= normal_state;
            ready_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == normal_state);
        end
    end

    // Resume timer counts the cycles spent waiting for ready after the wake write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_cnt_ff <= 32'h0000_0000;
        end else if (state_ff == resuming_state) begin
            resume_cnt_ff <= resume_cnt_ff + 32'd1;
        end else begin
            resume_cnt_ff <= 32'h0000_0000;
        end
    end

    // Read-first lock: cleared by reset and by waking, released by any completed read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_seen_ff <= 1'b0;
        end else if (wake_wr) begin
            read_seen_ff <= 1'b0;
        end else if (rd_acc) begin
            read_seen_ff <= 1'b1;
        end
    end

    // Bus answer, registered in the setup cycle so all outputs come from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            if (setup) begin
                pslverr_ff <= ~mapped | (~pwrite & ~rd_ok);
                if (!pwrite && rd_ok) begin
                    if (paddr == `PMC_OFFSET) begin
                        prdata_ff[`PMC_READY_BIT] <= ready_ff;
                        prdata_ff[`PMC_PULSE_SEL_BIT] <= pulse_sel_ff;
                        prdata_ff[`PMC_ENERGY_EN_BIT] <= energy_en_ff;
                        prdata_ff[`PMC_FRAME_EN_BIT] <= frame_en_ff;
                        prdata_ff[`PMC_PIN_EN_BIT] <= pin_en_ff;
                        prdata_ff[`PMC_WSS_LSB +: 2] <= wss_ff;
                        // Only the two sleep states show a nonzero code.
                        prdata_ff[`PMC_PSS_LSB +: 2] <= (state_ff == sleep_wol_state) ? `PSS_WOL :
                                                        (state_ff == sleep_energy_state) ? `PSS_ENERGY : `PSS_NORMAL;
                    end else if (paddr == `WAKE_TEST_OFFSET) begin
                        prdata_ff <= `WAKE_TEST_VALUE;
                    end else if (paddr == `IRQ_FLAGS_OFFSET) begin
                        prdata_ff[`IRQ_WAKE_BIT] <= irq_flag_ff;
                    end else if (paddr == `IRQ_ENABLE_OFFSET) begin
                        prdata_ff[`IRQ_WAKE_BIT] <= irq_en_ff;
                    end else if (paddr == `PHY_CTRL_OFFSET) begin
                        prdata_ff[`PHY_GEN_PD_BIT] <= phy_gen_pd_ff;
                        prdata_ff[`PHY_ENERGY_PD_BIT] <= phy_energy_pd_ff;
                    end else begin
                        prdata_ff[4:0] <= clk_gate_ff;
                    end
                end
            end
        end
    end

    // Wake configuration bits; held through sleep since writes are locked out there.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_sel_ff <= 1'b0;
            energy_en_ff <= 1'b0;
            frame_en_ff <= 1'b0;
            pin_en_ff <= 1'b0;
        end else if (wr_pmc) begin
            pulse_sel_ff <= pwdata[`PMC_PULSE_SEL_BIT];
            energy_en_ff <= pwdata[`PMC_ENERGY_EN_BIT];
            frame_en_ff <= pwdata[`PMC_FRAME_EN_BIT];
            pin_en_ff <= pwdata[`PMC_PIN_EN_BIT];
        end
    end

    // Wake source status: detection sets, write-one clears while ready, and a set wins.
    always_comb begin
        nxt_wss = wss_ff;
        if (wr_pmc) begin
            nxt_wss = wss_ff & ~pwdata[`PMC_WSS_LSB +: 2];
        end
        if (state_ff == sleep_wol_state && wake_frame_detected) begin
            nxt_wss = `WSS_FRAME;
        end
        // Carrier is a level, so one present at entry is seen in the first sleep cycle.
        if (state_ff == sleep_energy_state && carrier_present) begin
            nxt_wss = `WSS_ENERGY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wss_ff <= 2'h0;
        end else begin
            wss_ff <= nxt_wss;
        end
    end

    // Interrupt flag: held while the wake event lasts, write-one clears it after that.
    always_comb begin
        nxt_irq_flag = irq_flag_ff;
        if (wr_irq && pwdata[`IRQ_WAKE_BIT]) begin
            nxt_irq_flag = 1'b0;
        end
        if (wake_event) begin
            nxt_irq_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_ff <= 1'b0;
            irq_en_ff <= 1'b0;
            host_irq_ff <= 1'b0;
        end else begin
            irq_flag_ff <= nxt_irq_flag;
            if (wr_irq_en) begin
                irq_en_ff <= pwdata[`IRQ_WAKE_BIT];
            end
            host_irq_ff <= nxt_irq_flag & (wr_irq_en ? pwdata[`IRQ_WAKE_BIT] : irq_en_ff);
        end
    end

    // Wake pin: held while requested, or cut to the pulse length in pulse mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_req_d_ff <= 1'b0;
            pulse_cnt_ff <= 32'h0000_0000;
            pin_ff <= 1'b0;
        end else begin
            pin_req_d_ff <= pin_req;
            if (!pin_req) begin
                pulse_cnt_ff <= 32'h0000_0000;
            end else if (pin_rise) begin
                pulse_cnt_ff <= PULSE_CYCLES - 32'd1;
            end else if (pulse_cnt_ff != 32'h0000_0000) begin
                pulse_cnt_ff <= pulse_cnt_ff - 32'd1;
            end
            pin_ff <= pin_req & (~pulse_sel_ff | pin_rise | (pulse_cnt_ff != 32'h0000_0000));
        end
    end

    // Clock gates follow the state being entered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_gate_ff <= '{phy: 1'b1, rx_pm: 1'b1, internal: 1'b1, mac: 1'b1, host_if: 1'b1};
        end else begin
            unique case (nxt_state)
                sleep_wol_state: clk_gate_ff <= '{phy: 1'b1, rx_pm: 1'b1, internal: 1'b1, mac: 1'b0,
                                                  host_if: 1'b0};
                sleep_energy_state: clk_gate_ff <= '{phy: 1'b0, rx_pm: 1'b0, internal: 1'b0, mac: 1'b0,
                                                     host_if: 1'b0};
                normal_state, resuming_state: clk_gate_ff <= '{phy: 1'b1, rx_pm: 1'b1, internal: 1'b1,
                                                                mac: 1'b1, host_if: 1'b1};
            endcase
        end
    end

    // PHY power controls; clearing general powerdown gives a one-cycle PHY reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_gen_pd_ff <= 1'b0;
            phy_energy_pd_ff <= 1'b0;
            phy_reset_ff <= 1'b0;
        end else begin
            phy_reset_ff <= 1'b0;
            if (wr_phy) begin
                phy_gen_pd_ff <= pwdata[`PHY_GEN_PD_BIT];
                phy_energy_pd_ff <= pwdata[`PHY_ENERGY_PD_BIT];
                phy_reset_ff <= phy_gen_pd_ff & ~pwdata[`PHY_GEN_PD_BIT];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign wake_event_pin = pin_ff;
    assign host_irq = host_irq_ff;
    assign clk_gate = clk_gate_ff;
    assign phy_powerdown = phy_gen_pd_ff;
    assign phy_energy_powerdown = phy_energy_pd_ff;
    assign phy_reset = phy_reset_ff;

    // Checks on the design's own behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enter_wol_a: assert property (wr_pmc && state_ff == normal_state && pss_wr == `PSS_WOL |=>
        state_ff == sleep_wol_state && !ready_ff) else $error("wol sleep not entered");
    enter_energy_a: assert property (wr_pmc && state_ff == normal_state && pss_wr == `PSS_ENERGY |=>
        state_ff == sleep_energy_state && !ready_ff) else $error("energy sleep not entered");
    sleep_not_ready_a: assert property (sleeping |-> !ready_ff && !wr_pmc) else $error("ready in sleep");
    sleep_read_err_a: assert property (setup && sleeping && !pwrite && paddr != `PMC_OFFSET |=>
        pslverr_ff && prdata_ff == 32'h0000_0000) else $error("forbidden read served");
    wake_write_a: assert property (wake_wr |=> state_ff == resuming_state ##1 !read_seen_ff || rd_acc)
        else $error("wake write ignored");
    read_first_a: assert property (wr_acc && !read_seen_ff && state_ff == normal_state |=>
        $stable(pin_en_ff) && $stable(irq_en_ff) && state_ff == normal_state) else $error("write before read");
    wol_detect_a: assert property (state_ff == sleep_wol_state && wake_frame_detected |=>
        wss_ff == `WSS_FRAME) else $error("frame wake not latched");
    energy_detect_a: assert property ($rose(state_ff == sleep_energy_state) && carrier_present |=>
        wss_ff == `WSS_ENERGY) else $error("carrier at entry missed");
    irq_flag_set_a: assert property (wake_event |=> irq_flag_ff [*2] or (irq_flag_ff ##1 !wake_event))
        else $error("irq flag not set");
    irq_hold_a: assert property (irq_flag_ff && wake_event |=> irq_flag_ff) else $error("irq flag lost");
    pin_gate_a: assert property (!pin_req |=> !wake_event_pin) else $error("pin without request");
    pin_hold_a: assert property (!pulse_sel_ff && pin_req ##1 pin_req && !pulse_sel_ff |->
        wake_event_pin) else $error("static pin dropped");
    pulse_len_a: assert property (wake_event_pin && pulse_sel_ff && pulse_cnt_ff == 32'h0000_0000 &&
        pin_req_d_ff |=> !wake_event_pin || pin_rise) else $error("pulse too long");
    clocks_wol_a: assert property (state_ff == sleep_wol_state |-> clk_gate_ff.phy && clk_gate_ff.internal &&
        !clk_gate_ff.mac && !clk_gate_ff.host_if) else $error("wol clock gating wrong");
    clocks_energy_a: assert property (state_ff == sleep_energy_state |-> clk_gate_ff == 5'h00)
        else $error("energy clock gating wrong");
    resume_bound_a: assert property (state_ff == resuming_state |-> resume_cnt_ff < RESUME_CYCLES)
        else $error("ready late after wake");
    phy_reset_a: assert property (wr_phy && phy_gen_pd_ff && !pwdata[`PHY_GEN_PD_BIT] |=>
        phy_reset && !phy_powerdown ##1 !phy_reset) else $error("phy reset not pulsed");
    pss_code_a: assert property (setup && !pwrite && paddr == `PMC_OFFSET && state_ff == normal_state |=>
        prdata_ff[`PMC_PSS_LSB +: 2] == `PSS_NORMAL) else $error("state code not 00");

endmodule
`default_nettype wire

// [verif/wake_source_model.sv]
// Model of the line side that reports wake frames and carrier to the power state manager.
`default_nettype none
module wake_source_model (
    input wire logic pclk,
    output logic wake_frame_detected,
    output logic carrier_present
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both indications start quiet.
    initial begin
        wake_frame_detected = 1'b0;
        carrier_present = 1'b0;
    end

    // A matched wake frame shows as a single-cycle pulse.
    task automatic send_frame();
        @(posedge pclk);
        wake_frame_detected <= 1'b1;
        @(posedge pclk);
        wake_frame_detected <= 1'b0;
    endtask

    // Carrier is a level that follows the line energy.
    task automatic set_carrier(input logic v);
        @(posedge pclk);
        carrier_present <= v;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the power state manager over its APB registers.
`default_nettype none
`include "pwr_state_mgr_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench
    import pwr_state_mgr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RES = 20;
    localparam int PUL = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, wake_frame_detected, carrier_present, wake_event_pin, host_irq;
    logic phy_powerdown, phy_energy_powerdown, phy_reset;
    clk_gate_t clk_gate;
    int num_errors = 0;
    int check_count = 0;
    int pin_hi_cnt = 0;
    int rst_cnt = 0;

    // A 100 MHz clock.
    always #5 pclk = ~pclk;

    ethernet_power_state_manager #(.RESUME_CYCLES(RES), .PULSE_CYCLES(PUL)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_frame_detected(wake_frame_detected), .carrier_present(carrier_present),
        .wake_event_pin(wake_event_pin), .host_irq(host_irq), .clk_gate(clk_gate),
        .phy_powerdown(phy_powerdown), .phy_energy_powerdown(phy_energy_powerdown), .phy_reset(phy_reset));

    wake_source_model u_src (.pclk(pclk), .wake_frame_detected(wake_frame_detected),
        .carrier_present(carrier_present));

    // Counts wake pin high cycles and PHY reset pulses.
    always @(posedge pclk) begin
        if (wake_event_pin === 1'b1) pin_hi_cnt <= pin_hi_cnt + 1;
        if (phy_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    // One APB transfer; the request holds until pready is seen high at a rising edge.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits for the rising edge that sees pready high; only the watchdog ends a hang here.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Lets the commit edge settle so callers compare the updated outputs.
        @(negedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    // Reads a register and compares data and error flag.
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        `CHK(rd, e)
        `CHK(er, 1'b0)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run of a few hundred cycles.
    initial begin
        #50us;
        num_errors++;
        report_and_stop();
    end

    // Main sequence: reset, lock, both sleep states, wake, flags and PHY control.
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(`IRQ_ENABLE_OFFSET, 32'h1);
        rchk(`PMC_OFFSET, 32'h1);
        rchk(`IRQ_ENABLE_OFFSET, 32'h0);
        rchk(`CLK_STATUS_OFFSET, 32'h1f);
        apb(12'h020, 1'b0, 32'h0);
        `CHK(er, 1'b1)
        // Frame wake sleep with a held pin.
        wr(`IRQ_ENABLE_OFFSET, 32'h1);
        wr(`PMC_OFFSET, 32'h0000_1018);
        rchk(`PMC_OFFSET, 32'h0000_1018);
        `CHK(clk_gate, 5'b11100)
        apb(`IRQ_FLAGS_OFFSET, 1'b0, 32'h0);
        `CHK(er, 1'b1)
        wr(`PHY_CTRL_OFFSET, 32'h1);
        u_src.send_frame();
        idle(4);
        rchk(`PMC_OFFSET, 32'h0000_1218);
        `CHK(wake_event_pin, 1'b1)
        `CHK(host_irq, 1'b1)
        idle(30);
        `CHK(wake_event_pin, 1'b1)
        `CHK(phy_powerdown, 1'b0)
        wr(`WAKE_TEST_OFFSET, 32'h0);
        rchk(`PMC_OFFSET, 32'h0000_0218);
        idle(RES + 4);
        rchk(`PMC_OFFSET, 32'h0000_0219);
        wr(`IRQ_FLAGS_OFFSET, 32'h1);
        rchk(`IRQ_FLAGS_OFFSET, 32'h1);
        wr(`PMC_OFFSET, 32'h0000_0318);
        idle(3);
        `CHK(wake_event_pin, 1'b0)
        wr(`IRQ_FLAGS_OFFSET, 32'h1);
        rchk(`IRQ_FLAGS_OFFSET, 32'h0);
        `CHK(host_irq, 1'b0)
        // Energy sleep entered with carrier already on the line, pulsed pin.
        wr(`PHY_CTRL_OFFSET, 32'h2);
        `CHK(phy_energy_powerdown, 1'b1)
        u_src.set_carrier(1'b1);
        pin_hi_cnt = 0;
        wr(`PMC_OFFSET, 32'h0000_2016);
        idle(2);
        rchk(`PMC_OFFSET, 32'h0000_2116);
        `CHK({clk_gate.internal, clk_gate.mac, clk_gate.host_if}, 3'b000)
        idle(40);
        `CHK(pin_hi_cnt, PUL)
        `CHK(wake_event_pin, 1'b0)
        wr(`WAKE_TEST_OFFSET, 32'h0);
        idle(RES + 4);
        rchk(`PMC_OFFSET, 32'h0000_0117);
        wr(`PHY_CTRL_OFFSET, 32'h0);
        `CHK(phy_energy_powerdown, 1'b0)
        // The unused state code leaves the device awake.
        wr(`PMC_OFFSET, 32'h0000_3316);
        rchk(`PMC_OFFSET, 32'h0000_0017);
        `CHK(clk_gate, 5'b11111)
        // General powerdown and the reset pulse on its release.
        wr(`PHY_CTRL_OFFSET, 32'h1);
        `CHK(phy_powerdown, 1'b1)
        rst_cnt = 0;
        wr(`PHY_CTRL_OFFSET, 32'h0);
        idle(2);
        `CHK(rst_cnt, 1)
        `CHK(phy_powerdown, 1'b0)
        report_and_stop();
    end
endmodule
`default_nettype wire
